// File: rtl/sbcmi_defs.vh
// Constants for the system basis chip host interface block.
`ifndef SBCMI_DEFS_VH
`define SBCMI_DEFS_VH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define SBCMI_CLK_MHZ 100
`define SBCMI_T_RSTHOLD_US 1000
`define SBCMI_RSTHOLD_CYC (`SBCMI_T_RSTHOLD_US * `SBCMI_CLK_MHZ)
`define SBCMI_T_RSTDF_NS 600
`define SBCMI_RSTDF_CYC ((`SBCMI_T_RSTDF_NS * `SBCMI_CLK_MHZ) / 1000)
`define SBCMI_T_TXDDOM_MS 1000
`define SBCMI_TXDDOM_CYC (`SBCMI_T_TXDDOM_MS * `SBCMI_CLK_MHZ * 1000)
`define SBCMI_T_WUBUS_US 70
`define SBCMI_WUBUS_CYC (`SBCMI_T_WUBUS_US * `SBCMI_CLK_MHZ)
`define SBCMI_T_WUSTOP_US 13
`define SBCMI_WUSTOP_CYC (`SBCMI_T_WUSTOP_US * `SBCMI_CLK_MHZ)
`define SBCMI_T_WUSPI_US 90
`define SBCMI_WUSPI_CYC (`SBCMI_T_WUSPI_US * `SBCMI_CLK_MHZ)
`define SBCMI_T_NRTOUT_MS 150
`define SBCMI_NRTOUT_CYC (`SBCMI_T_NRTOUT_MS * `SBCMI_CLK_MHZ * 1000)
`define SBCMI_T_WDDEF_MS 150
`define SBCMI_WDDEF_CYC (`SBCMI_T_WDDEF_MS * `SBCMI_CLK_MHZ * 1000)
`define SBCMI_T_WDEXT_MS 10
`define SBCMI_WDEXT_CYC (`SBCMI_T_WDEXT_MS * `SBCMI_CLK_MHZ * 1000)

// ----------------------------------------------------------------
// Serial frame layout
// ----------------------------------------------------------------
`define SBCMI_FRAME_BITS 4'h8
`define SBCMI_OP_MSB 7
`define SBCMI_OP_LSB 5
`define SBCMI_OP_STATUS 3'h0
`define SBCMI_OP_MODE 3'h1
`define SBCMI_OP_WDTRIG 3'h2
`define SBCMI_OP_HSCTL 3'h3
`define SBCMI_OP_MUXSEL 3'h4
`define SBCMI_MODE_REQ_STOP 2'h1
`define SBCMI_MODE_REQ_SLEEP 2'h2
`define SBCMI_HS_A_BIT 0
`define SBCMI_HS_B_BIT 1
`define SBCMI_HS_PWM_BIT 2
`define SBCMI_HSCTL_RST 3'h0
`define SBCMI_MUXSEL_RST 3'h0

// ----------------------------------------------------------------
// Status byte layout and mode codes
// ----------------------------------------------------------------
`define SBCMI_ST_WAKE_BIT 7
`define SBCMI_ST_TXDF_BIT 6
`define SBCMI_ST_WDOFF_BIT 5
`define SBCMI_ST_PWM_BIT 4
`define SBCMI_MCODE_RESET 3'h0
`define SBCMI_MCODE_NREQ 3'h1
`define SBCMI_MCODE_NORMAL 3'h2
`define SBCMI_MCODE_STOP 3'h3
`define SBCMI_MCODE_SLEEP 3'h4

`endif

// File: rtl/sbcmi_filt.v
// Two-flop synchroniser followed by a stability filter.
`timescale 1ns/100ps
`default_nettype none
module sbcmi_filt #(
    parameter INIT = 1'b1,
    parameter LEN = 60
) (
    input wire clk,
    input wire sys_rst,
    input wire din,
    output reg dout
);
    reg meta_r;
    reg sync_r;
    reg [31:0] cnt_r;

    // ----------------------------------------------------------------
    // Synchronise, then accept a new level only after LEN stable cycles
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (sys_rst) begin
            meta_r <= INIT;
            sync_r <= INIT;
            cnt_r <= 32'h0;
            dout <= INIT;
        end else begin
            meta_r <= din;
            sync_r <= meta_r;
            if (sync_r == dout) begin
                cnt_r <= 32'h0;
            end else if (cnt_r >= LEN - 1) begin
                cnt_r <= 32'h0;
                dout <= sync_r;
            end else begin
                cnt_r <= cnt_r + 32'h1;
            end
        end
    end
endmodule
`default_nettype wire

// File: rtl/sbcmi_top.v
// Host-side digital interface of the system basis chip.
`timescale 1ns/100ps
`default_nettype none
`include "sbcmi_defs.vh"
module sbcmi_top #(
    parameter RSTHOLD_CYC = `SBCMI_RSTHOLD_CYC,
    parameter RSTDF_CYC = `SBCMI_RSTDF_CYC,
    parameter TXDDOM_CYC = `SBCMI_TXDDOM_CYC,
    parameter WUBUS_CYC = `SBCMI_WUBUS_CYC,
    parameter WUSTOP_CYC = `SBCMI_WUSTOP_CYC,
    parameter WUSPI_CYC = `SBCMI_WUSPI_CYC,
    parameter NRTOUT_CYC = `SBCMI_NRTOUT_CYC,
    parameter WDDEF_CYC = `SBCMI_WDDEF_CYC,
    parameter WDEXT_CYC = `SBCMI_WDEXT_CYC
) (
    input wire clk,
    input wire sys_rst,
    input wire sclk,
    input wire cs_n,
    input wire mosi,
    output reg miso_o,
    output reg miso_oe_n,
    input wire lin_txd,
    output reg lin_rxd,
    input wire lin_bus_recessive,
    output reg lin_bus_dominant,
    input wire pulse_drive_input,
    output reg high_side_switch_a,
    output reg high_side_switch_b,
    output reg [2:0] analog_mux_sel,
    input wire rst_line_i,
    output wire rst_line_o,
    output reg rst_line_oe_n,
    output reg irq_n,
    input wire wd_strap_gnd,
    input wire wd_strap_open,
    input wire vdd_low,
    output reg [2:0] mode_code
);
    localparam [4:0] M_RESET = 5'h01;
    localparam [4:0] M_NREQ = 5'h02;
    localparam [4:0] M_NORMAL = 5'h04;
    localparam [4:0] M_STOP = 5'h08;
    localparam [4:0] M_SLEEP = 5'h10;

    // ----------------------------------------------------------------
    // Input synchronisers for the pins on foreign timing
    // ----------------------------------------------------------------
    reg [7:0] meta_r;
    reg [7:0] sync_r;
    reg sclk_d_r;
    reg cs_n_d_r;
    reg [1:0] bus_rec_sync_r;
    wire sclk_s = sync_r[0];
    wire cs_n_s = sync_r[1];
    wire mosi_s = sync_r[2];
    wire txd_s = sync_r[3];
    wire pwm_s = sync_r[4];
    wire strap_gnd_s = sync_r[5];
    wire strap_open_s = sync_r[6];
    wire vdd_low_s = sync_r[7];

    always @(posedge clk) begin
        if (sys_rst) begin
            meta_r <= 8'h1A;
            sync_r <= 8'h1A;
            sclk_d_r <= 1'b0;
            cs_n_d_r <= 1'b1;
            bus_rec_sync_r <= 2'h3;
        end else begin
            meta_r <= {vdd_low, wd_strap_open, wd_strap_gnd, pulse_drive_input,
                       lin_txd, mosi, cs_n, sclk};
            sync_r <= meta_r;
            sclk_d_r <= sclk_s;
            cs_n_d_r <= cs_n_s;
            bus_rec_sync_r <= {bus_rec_sync_r[0], lin_bus_recessive};
        end
    end

    wire sclk_rise = sclk_s & ~sclk_d_r;
    wire sclk_fall = ~sclk_s & sclk_d_r;
    wire cs_fall = ~cs_n_s & cs_n_d_r;
    wire cs_rise = cs_n_s & ~cs_n_d_r;

    // ----------------------------------------------------------------
    // Filtered reset line and bus wake-up detectors
    // ----------------------------------------------------------------
    wire rst_filt;
    wire bus_wu_sleep;
    wire bus_wu_stop;

    sbcmi_filt #(.INIT(1'b0), .LEN(RSTDF_CYC)) u_rst_filt (
        .clk(clk),
        .sys_rst(sys_rst),
        .din(rst_line_i),
        .dout(rst_filt)
    );

    sbcmi_filt #(.INIT(1'b1), .LEN(WUBUS_CYC)) u_wu_sleep (
        .clk(clk),
        .sys_rst(sys_rst),
        .din(lin_bus_recessive),
        .dout(bus_wu_sleep)
    );

    sbcmi_filt #(.INIT(1'b1), .LEN(WUSTOP_CYC)) u_wu_stop (
        .clk(clk),
        .sys_rst(sys_rst),
        .din(lin_bus_recessive),
        .dout(bus_wu_stop)
    );

    // Only the driver low state is ever put on the line.
    assign rst_line_o = 1'b0;

    // ----------------------------------------------------------------
    // Serial shift engine
    // ----------------------------------------------------------------
    reg [4:0] mode_r;
    reg [4:0] mode_nxt;
    reg [7:0] rx_sh_r;
    reg [7:0] tx_sh_r;
    reg [3:0] bit_cnt_r;
    reg [31:0] spi_blk_r;
    reg wake_flag_r;
    reg txd_fault_r;
    reg txd_fault_flag_r;
    reg [2:0] hsctl_r;
    wire [7:0] status_byte;
    wire spi_blocked = (spi_blk_r != 32'h0);

    assign status_byte = {wake_flag_r, txd_fault_flag_r, strap_gnd_s,
                          hsctl_r[`SBCMI_HS_PWM_BIT], 1'b0, mode_code};

    always @(posedge clk) begin
        if (sys_rst) begin
            rx_sh_r <= 8'h00;
            tx_sh_r <= 8'h00;
            bit_cnt_r <= 4'h0;
            miso_o <= 1'b0;
            miso_oe_n <= 1'b1;
        end else begin
            miso_oe_n <= cs_n_s;
            if (cs_fall) begin
                tx_sh_r <= {status_byte[6:0], 1'b0};
                miso_o <= status_byte[7];
                bit_cnt_r <= 4'h0;
            end else if (!cs_n_s) begin
                if (sclk_rise) begin
                    rx_sh_r <= {rx_sh_r[6:0], mosi_s};
                    if (bit_cnt_r != 4'hF) begin
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end
                end
                if (sclk_fall) begin
                    miso_o <= tx_sh_r[7];
                    tx_sh_r <= {tx_sh_r[6:0], 1'b0};
                end
            end
        end
    end

    // A frame counts only with exactly eight clocks and no wake blanking.
    wire frame_ok = cs_rise && (bit_cnt_r == `SBCMI_FRAME_BITS)
                    && !spi_blocked;
    wire [2:0] op = rx_sh_r[`SBCMI_OP_MSB:`SBCMI_OP_LSB];
    wire active = mode_r[1] | mode_r[2];
    wire cmd_ok = frame_ok && active;
    wire cmd_status = cmd_ok && (op == `SBCMI_OP_STATUS);
    wire cmd_wdtrig = cmd_ok && (op == `SBCMI_OP_WDTRIG);
    wire cmd_stop = cmd_ok && (op == `SBCMI_OP_MODE)
                    && (rx_sh_r[1:0] == `SBCMI_MODE_REQ_STOP);
    wire cmd_sleep = cmd_ok && (op == `SBCMI_OP_MODE)
                     && (rx_sh_r[1:0] == `SBCMI_MODE_REQ_SLEEP);

    // ----------------------------------------------------------------
    // Control registers written over the serial port
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (sys_rst || mode_r == M_RESET) begin
            hsctl_r <= `SBCMI_HSCTL_RST;
            analog_mux_sel <= `SBCMI_MUXSEL_RST;
        end else if (cmd_ok) begin
            if (op == `SBCMI_OP_HSCTL) begin
                hsctl_r <= rx_sh_r[2:0];
            end
            if (op == `SBCMI_OP_MUXSEL) begin
                analog_mux_sel <= rx_sh_r[2:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Timers: reset hold, request timeout, watchdog, dominant fault
    // ----------------------------------------------------------------
    reg [31:0] tmr_r;
    reg [31:0] wd_r;
    reg [31:0] txd_cnt_r;
    reg rst_drive_r;
    wire wd_off = strap_gnd_s;
    wire [31:0] wd_len = strap_open_s ? WDDEF_CYC : WDEXT_CYC;
    wire wd_expire = mode_r == M_NORMAL && !wd_off && wd_r >= wd_len - 1;
    wire nreq_expire = mode_r == M_NREQ && tmr_r >= NRTOUT_CYC - 1;
    wire hold_done = tmr_r >= RSTHOLD_CYC - 1;
    wire stop_cs_wake = mode_r == M_STOP && cs_rise;
    wire stop_bus_wake = mode_r == M_STOP && !bus_wu_stop;
    wire sleep_bus_wake = mode_r == M_SLEEP && !bus_wu_sleep;
    wire host_reset = !rst_filt && !rst_drive_r && mode_r != M_RESET;
    wire go_reset = vdd_low_s || wd_expire || nreq_expire
                    || sleep_bus_wake || host_reset;

    always @(posedge clk) begin
        if (sys_rst) begin
            tmr_r <= 32'h0;
            wd_r <= 32'h0;
            spi_blk_r <= 32'h0;
        end else begin
            if (mode_r != mode_nxt) begin
                tmr_r <= 32'h0;
            end else if (!hold_done || mode_r == M_NREQ) begin
                tmr_r <= tmr_r + 32'h1;
            end
            if (mode_r != M_NORMAL || cmd_wdtrig || wd_off) begin
                wd_r <= 32'h0;
            end else begin
                wd_r <= wd_r + 32'h1;
            end
            if (stop_cs_wake) begin
                spi_blk_r <= WUSPI_CYC;
            end else if (spi_blocked) begin
                spi_blk_r <= spi_blk_r - 32'h1;
            end
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            txd_cnt_r <= 32'h0;
            txd_fault_r <= 1'b0;
        end else if (txd_s || !active) begin
            txd_cnt_r <= 32'h0;
            txd_fault_r <= 1'b0;
        end else if (txd_cnt_r >= TXDDOM_CYC - 1) begin
            txd_fault_r <= 1'b1;
        end else begin
            txd_cnt_r <= txd_cnt_r + 32'h1;
        end
    end

    // ----------------------------------------------------------------
    // Operating mode sequencer
    // ----------------------------------------------------------------
    always @* begin
        mode_nxt = mode_r;
        case (mode_r)
            M_RESET: begin
                // Leave as soon as nobody holds the line, host or device.
                if (!rst_drive_r && rst_filt && !vdd_low_s) begin
                    mode_nxt = M_NREQ;
                end
            end
            M_NREQ: begin
                if (go_reset) begin
                    mode_nxt = M_RESET;
                end else if (cmd_wdtrig) begin
                    mode_nxt = M_NORMAL;
                end
            end
            M_NORMAL: begin
                if (go_reset) begin
                    mode_nxt = M_RESET;
                end else if (cmd_stop) begin
                    mode_nxt = M_STOP;
                end else if (cmd_sleep) begin
                    mode_nxt = M_SLEEP;
                end
            end
            M_STOP: begin
                if (go_reset) begin
                    mode_nxt = M_RESET;
                end else if (stop_cs_wake || stop_bus_wake) begin
                    mode_nxt = M_NREQ;
                end
            end
            M_SLEEP: begin
                if (go_reset) begin
                    mode_nxt = M_RESET;
                end
            end
            default: begin
                mode_nxt = M_RESET;
            end
        endcase
    end

    // Power-up lands in the reset mode, so the hold is applied then too.
    always @(posedge clk) begin
        if (sys_rst) begin
            mode_r <= M_RESET;
            rst_drive_r <= 1'b1;
        end else begin
            mode_r <= mode_nxt;
            if (mode_nxt == M_RESET && mode_r != M_RESET) begin
                rst_drive_r <= !host_reset;
            end else if (mode_r == M_RESET && hold_done) begin
                rst_drive_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Sticky event flags and interrupt output
    // ----------------------------------------------------------------
    // A new event in the clearing cycle survives: set beats clear, but a read clears a set fault flag; a lasting fault sets it again.
    always @(posedge clk) begin
        if (sys_rst) begin
            wake_flag_r <= 1'b0;
            txd_fault_flag_r <= 1'b0;
        end else begin
            if (stop_cs_wake || stop_bus_wake) begin
                wake_flag_r <= 1'b1;
            end else if (cmd_status) begin
                wake_flag_r <= 1'b0;
            end
            if (txd_fault_r && active && !txd_fault_flag_r
                && txd_cnt_r >= TXDDOM_CYC - 1) begin
                txd_fault_flag_r <= 1'b1;
            end else if (cmd_status) begin
                txd_fault_flag_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin outputs
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (sys_rst) begin
            lin_rxd <= 1'b1;
            lin_bus_dominant <= 1'b0;
            high_side_switch_a <= 1'b0;
            high_side_switch_b <= 1'b0;
            rst_line_oe_n <= 1'b1;
            irq_n <= 1'b1;
            mode_code <= `SBCMI_MCODE_RESET;
        end else begin
            lin_rxd <= active ? bus_rec_sync_r[1] : 1'b1;
            // Normal Request listens only; transmit needs Normal.
            lin_bus_dominant <= mode_r == M_NORMAL && !txd_s
                                && !txd_fault_r;
            high_side_switch_a <= active && hsctl_r[`SBCMI_HS_A_BIT]
                && (!hsctl_r[`SBCMI_HS_PWM_BIT] || pwm_s);
            high_side_switch_b <= active && hsctl_r[`SBCMI_HS_B_BIT]
                && (!hsctl_r[`SBCMI_HS_PWM_BIT] || pwm_s);
            rst_line_oe_n <= !rst_drive_r;
            irq_n <= !(wake_flag_r || txd_fault_flag_r);
            case (mode_r)
                M_NREQ: mode_code <= `SBCMI_MCODE_NREQ;
                M_NORMAL: mode_code <= `SBCMI_MCODE_NORMAL;
                M_STOP: mode_code <= `SBCMI_MCODE_STOP;
                M_SLEEP: mode_code <= `SBCMI_MCODE_SLEEP;
                default: mode_code <= `SBCMI_MCODE_RESET;
            endcase
        end
    end
endmodule
`default_nettype wire

// File: tb/sbcmi_checker.sv
// Port-level assertions for the system basis chip host interface.
`timescale 1ns/100ps
`default_nettype none
module sbcmi_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso_o,
    input wire logic miso_oe_n,
    input wire logic lin_txd,
    input wire logic lin_rxd,
    input wire logic lin_bus_recessive,
    input wire logic lin_bus_dominant,
    input wire logic pulse_drive_input,
    input wire logic high_side_switch_a,
    input wire logic high_side_switch_b,
    input wire logic [2:0] analog_mux_sel,
    input wire logic rst_line_i,
    input wire logic rst_line_o,
    input wire logic rst_line_oe_n,
    input wire logic irq_n,
    input wire logic wd_strap_gnd,
    input wire logic wd_strap_open,
    input wire logic vdd_low,
    input wire logic [2:0] mode_code
);
    // ----
    // Checks
    // ----
    // Three cycles of synchroniser and register slack are allowed.
    logic act;
    assign act = (mode_code == 3'h1) || (mode_code == 3'h2);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_miso_float: assert property (cs_n [*4] |-> miso_oe_n)
        else $error("miso driven while deselected");
    a_miso_drive: assert property ((!cs_n) [*4] |-> !miso_oe_n)
        else $error("miso not driven while selected");
    a_rxd_idle: assert property ((!act) [*2] |-> lin_rxd)
        else $error("receive output active in low mode");
    a_rxd_dom: assert property (((mode_code == 3'h2)
        && !lin_bus_recessive) [*5] |-> !lin_rxd)
        else $error("receive output high on dominant bus");
    a_rxd_rec: assert property ((act && lin_bus_recessive) [*5]
        |-> lin_rxd)
        else $error("receive output low on recessive bus");
    a_bus_gate: assert property (lin_bus_dominant
        |-> (mode_code == 3'h2) || ($past(mode_code) == 3'h2))
        else $error("bus driven outside normal mode");
    a_txd_rec: assert property (lin_txd [*4] |-> !lin_bus_dominant)
        else $error("bus dominant with transmit high");
    a_hs_gate: assert property ((high_side_switch_a || high_side_switch_b)
        |-> act || $past(act))
        else $error("switch on outside active modes");
    a_rst_only_low: assert property (rst_line_o == 1'b0)
        else $error("reset line driven high");
    a_irq_wake: assert property ((mode_code == 3'h3) ##1 (mode_code == 3'h1)
        |-> ##[0:2] !irq_n)
        else $error("no interrupt after stop wake");
    a_irq_hold: assert property ((!irq_n && !cs_n && mode_code != 3'h0)
        |=> !irq_n)
        else $error("interrupt released without read");
    a_rst_release: assert property ((mode_code == 3'h0 && rst_line_oe_n
        && rst_line_i) [*8] |-> ##[0:8] mode_code == 3'h1)
        else $error("no normal request after reset release");
    c_wake: cover property ((mode_code == 3'h3) ##1 (mode_code == 3'h1));
    c_irq: cover property ($fell(irq_n));
    c_hs: cover property (high_side_switch_a && high_side_switch_b);
endmodule
bind sbcmi_top sbcmi_checker u_chk (.*);
`default_nettype wire

// File: tb/sbcmi_host.sv
// Host controller model: serial master driving the select, clock and data.
`timescale 1ns/100ps
`default_nettype none
module sbcmi_host (
    output var logic sclk,
    output var logic cs_n,
    output var logic mosi,
    input wire logic miso_line
);
    // ----
    // Frame
    // ----
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // A zero-bit frame is a bare select pulse, used as a wake request.
    task automatic xfer(input logic [7:0] tx, input int nbits,
                        output logic [7:0] rx);
        int i;
        rx = 8'h00;
        cs_n = 1'b0;
        #100;
        for (i = 0; i < nbits; i++) begin
            mosi = (i < 8) ? tx[7 - i] : 1'b0;
            #62.5 sclk = 1'b1;
            rx = {rx[6:0], miso_line};
            #62.5 sclk = 1'b0;
        end
        #100 cs_n = 1'b1;
        mosi = ~mosi;
        #4000;
    endtask
endmodule
`default_nettype wire

// File: tb/test_sbc_mcu_interface.sv
// Self-checking bench for the system basis chip host interface.
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp); \
    end \
end
module test_sbc_mcu_interface;
    // ----
    // Harness
    // ----
    logic clk, sys_rst, lin_txd, pulse_drive_input, wd_strap_gnd;
    logic wd_strap_open, vdd_low, other_dom, host_rst_n;
    logic flip_r = 1'b0;
    wire sclk, cs_n, mosi, miso_o, miso_oe_n, miso_line, lin_rxd;
    wire lin_bus_recessive, lin_bus_dominant, high_side_switch_a;
    wire high_side_switch_b, rst_line_i, rst_line_o, rst_line_oe_n, irq_n;
    wire [2:0] analog_mux_sel, mode_code;
    logic [7:0] rx;
    int mismatches = 0;
    int tests_run = 0;
    // A released data line toggles so a stale value is never read as valid.
    assign miso_line = miso_oe_n ? flip_r : miso_o;
    assign rst_line_i = rst_line_oe_n & host_rst_n;
    assign lin_bus_recessive = !lin_bus_dominant && !other_dom;
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) flip_r <= ~flip_r;
    sbcmi_top #(.RSTHOLD_CYC(50), .RSTDF_CYC(4), .TXDDOM_CYC(200),
        .WUSPI_CYC(600), .WDDEF_CYC(3000)) u_dut (.*);
    sbcmi_host u_host (.*);
    // ----
    // Scenarios
    // ----
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic t_boot;
        int n;
        n = 0;
        while (rst_line_oe_n !== 1'b0 && n < 9) begin
            @(posedge clk);
            n++;
        end
        n = 0;
        while (rst_line_oe_n === 1'b0 && n < 200) begin
            @(posedge clk);
            n++;
        end
        `CHK((n > 32) && (n < 68), 1'b1)
        settle(20);
        `CHK(mode_code, 3'h1)
    endtask
    task automatic t_lin;
        other_dom = 1'b1;
        lin_txd = 1'b0;
        settle(6);
        `CHK(lin_rxd, 1'b0)
        `CHK(lin_bus_dominant, 1'b0)
        other_dom = 1'b0;
        lin_txd = 1'b1;
        settle(6);
        `CHK(lin_rxd, 1'b1)
        u_host.xfer(8'h00, 8, rx);
        `CHK(rx, 8'h21)
        u_host.xfer(8'h40, 8, rx);
        `CHK(mode_code, 3'h2)
        lin_txd = 1'b0;
        settle(6);
        `CHK(lin_bus_dominant, 1'b1)
        `CHK(lin_rxd, 1'b0)
        lin_txd = 1'b1;
        settle(6);
        `CHK(lin_bus_dominant, 1'b0)
        lin_txd = 1'b0;
        settle(210);
        `CHK(lin_bus_dominant, 1'b0)
        `CHK(irq_n, 1'b0)
        lin_txd = 1'b1;
        u_host.xfer(8'h00, 8, rx);
        `CHK(rx, 8'h62)
        `CHK(irq_n, 1'b1)
    endtask
    task automatic t_hs;
        u_host.xfer(8'h63, 8, rx);
        `CHK({high_side_switch_a, high_side_switch_b}, 2'h3)
        u_host.xfer(8'h67, 8, rx);
        `CHK({high_side_switch_a, high_side_switch_b}, 2'h0)
        pulse_drive_input = 1'b1;
        settle(5000);
        `CHK(mode_code, 3'h2)
        `CHK({high_side_switch_a, high_side_switch_b}, 2'h3)
        u_host.xfer(8'h85, 8, rx);
        `CHK(analog_mux_sel, 3'h5)
        u_host.xfer(8'h82, 7, rx);
        `CHK(analog_mux_sel, 3'h5)
        u_host.xfer(8'h82, 9, rx);
        `CHK(analog_mux_sel, 3'h5)
    endtask
    task automatic t_stop;
        u_host.xfer(8'h21, 8, rx);
        `CHK(mode_code, 3'h3)
        `CHK(lin_rxd, 1'b1)
        `CHK({high_side_switch_a, high_side_switch_b}, 2'h0)
        u_host.xfer(8'h00, 0, rx);
        `CHK(mode_code, 3'h1)
        `CHK(irq_n, 1'b0)
        u_host.xfer(8'h00, 8, rx);
        `CHK(rx, 8'hB1)
        `CHK(irq_n, 1'b0)
        u_host.xfer(8'h00, 8, rx);
        `CHK(rx, 8'hB1)
        `CHK(irq_n, 1'b1)
    endtask
    task automatic t_sleep;
        u_host.xfer(8'h40, 8, rx);
        u_host.xfer(8'h22, 8, rx);
        other_dom = 1'b1;
        settle(6900);
        `CHK(mode_code, 3'h4)
        `CHK(lin_rxd, 1'b1)
        settle(130);
        `CHK(mode_code, 3'h0)
        other_dom = 1'b0;
        settle(60);
        `CHK(mode_code, 3'h1)
    endtask
    task automatic t_wdog;
        u_host.xfer(8'h40, 8, rx);
        wd_strap_gnd = 1'b0;
        wd_strap_open = 1'b1;
        settle(2950);
        `CHK(mode_code, 3'h2)
        settle(80);
        `CHK(mode_code, 3'h0)
        `CHK(rst_line_oe_n, 1'b0)
    endtask
    task automatic t_hostrst;
        host_rst_n = 1'b0;
        settle(2);
        host_rst_n = 1'b1;
        settle(10);
        `CHK(mode_code, 3'h1)
        host_rst_n = 1'b0;
        settle(20);
        `CHK(mode_code, 3'h0)
        host_rst_n = 1'b1;
        settle(20);
        `CHK(mode_code, 3'h1)
    endtask
    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ----
    // Sequence
    // ----
    initial begin
        sys_rst = 1'b1;
        lin_txd = 1'b1;
        other_dom = 1'b0;
        pulse_drive_input = 1'b0;
        host_rst_n = 1'b1;
        wd_strap_gnd = 1'b1;
        wd_strap_open = 1'b0;
        vdd_low = 1'b0;
        settle(12);
        sys_rst = 1'b0;
        t_boot;
        t_lin;
        t_hs;
        t_stop;
        t_hostrst;
        t_sleep;
        t_wdog;
        close_out;
    end
    // The whole sequence needs well under a millisecond.
    initial begin
        #1000000;
        mismatches++;
        close_out;
    end
endmodule
`default_nettype wire
